// file: pkg/fdcdm_cfg.svh
/*
 * constants of the four-decade counter and display scanner: register
 * offsets, field positions, reset values, pin slots and digit limits.
 * assumes inclusion by bare name from the package and the design files.
 */
// Behaviour
// - while latch_load_n is low the latches copy the live count continuously
// - after latch_load_n rises, latches freeze at the next count falling edge
// - reset low clears counters, scans top_digit, wrap flag high, overrides count and scan edges
// - the four-decade count increments by one, rippling its carry, on each count falling edge
// - cascade carry high at 9999 until next count fall or reset
// - wrap flag latches low on roll 9999 to 0000 until reset
// - leading zeros blank until nonzero digit or suppress stop goes low
// - bcd code and bottom_digit never zero suppressed; bottom strobe rearms suppression
// - suppress stop tied low disables leading zero suppression entirely
// - right point mode delays unblanking until the following digit
// - dp side select high means left point, low means right point
// - display blank low forces segments off, bcd to zero, scan continues
// - one-of-four scanner steps top to bottom on scan falling edge
// - scan low forces segments, strobes off and bcd to zero
// - polarity select low inverts both bcd code and segment outputs
`ifndef FDCDM_CFG_SVH
`define FDCDM_CFG_SVH

// register byte offsets
`define FDCDM_ADR_W 8
`define FDCDM_ADR_LIVE 8'h00
`define FDCDM_ADR_LATCH 8'h04
`define FDCDM_ADR_FLAGS 8'h08
`define FDCDM_ADR_IRQ_STAT 8'h0C
`define FDCDM_ADR_IRQ_MASK 8'h10

// flag register fields
`define FDCDM_FLAG_WRAP_N 0
`define FDCDM_FLAG_CARRY 1
`define FDCDM_FLAG_XFER 2
`define FDCDM_FLAG_STROBE 4

// interrupt bits
`define FDCDM_IRQ_W 3
`define FDCDM_IRQ_WRAP 0
`define FDCDM_IRQ_CARRY 1
`define FDCDM_IRQ_FREEZE 2
`define FDCDM_IRQ_RST 3'h0

// pin slots in the synchroniser vector
`define FDCDM_PIN_W 8
`define FDCDM_PIN_COUNT 0
`define FDCDM_PIN_SCAN 1
`define FDCDM_PIN_RESET 2
`define FDCDM_PIN_LATCH 3
`define FDCDM_PIN_ZS 4
`define FDCDM_PIN_DP 5
`define FDCDM_PIN_BLANK 6
`define FDCDM_PIN_POL 7
`define FDCDM_PIN_IDLE 8'hFF

// counting
`define FDCDM_DIGITS 4
`define FDCDM_DIGIT_W 4
`define FDCDM_NIB3 12
`define FDCDM_NIB2 8
`define FDCDM_NIB1 4
`define FDCDM_NIB0 0
`define FDCDM_DIGIT_MAX 4'h9
`define FDCDM_DIGIT_ZERO 4'h0
`define FDCDM_DIGIT_ONE 4'h1
`define FDCDM_COUNT_MAX 16'h9999
`define FDCDM_COUNT_ZERO 16'h0000

// output levels
`define FDCDM_SEG_OFF 7'h00
`define FDCDM_BCD_OFF 4'hF
`define FDCDM_STROBE_OFF 4'h0

`endif

// file: pkg/fdcdm_pkg.sv
/*
 * types shared by the counter/scanner design files.
 * assumes the cfg header sits on the include path.
 */
`default_nettype none
`include "fdcdm_cfg.svh"
package fdcdm_pkg;
    typedef logic [`FDCDM_DIGIT_W-1:0] fdcdm_digit_t;
    typedef logic [`FDCDM_DIGITS*`FDCDM_DIGIT_W-1:0] fdcdm_count_t;
    typedef logic [6:0] fdcdm_seg_t;
    typedef logic [31:0] fdcdm_word_t;
    // digit scanner, the code is the strobe pattern itself
    typedef enum logic [3:0] {
        FDCDM_DIG_TOP = 4'b0001,
        FDCDM_DIG_2 = 4'b0010,
        FDCDM_DIG_3 = 4'b0100,
        FDCDM_DIG_BOT = 4'b1000
    } fdcdm_scan_t;
endpackage
`default_nettype wire

// file: rtl/fdcdm_sync.sv
/*
 * two-flop synchroniser for the external pins of the counter block.
 * assumes inputs are asynchronous to clk_i; idle value after reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fdcdm_cfg.svh"
module fdcdm_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [`FDCDM_PIN_W-1:0] d_i,
    output logic [`FDCDM_PIN_W-1:0] q_o
);
    logic [`FDCDM_PIN_W-1:0] meta_q;
    // first stage is only read by the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= `FDCDM_PIN_IDLE;
            q_o <= `FDCDM_PIN_IDLE;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule // fdcdm_sync
`default_nettype wire

// file: rtl/fdcdm_top.sv
/*
 * four-decade bcd counter with transfer latches, carry and wrap flags,
 * multiplexed digit scanner with zero suppression, wishbone registers
 * and a masked interrupt. assumes count/scan edges far slower than clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fdcdm_cfg.svh"
module fdcdm_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`FDCDM_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire fdcdm_pkg::fdcdm_word_t wb_dat_i,
    output fdcdm_pkg::fdcdm_word_t wb_dat_o,
    output logic wb_ack_o,
    input wire logic count_i,
    input wire logic scan_i,
    input wire logic reset_n_i,
    input wire logic latch_load_n_i,
    input wire logic zero_suppress_stop_n_i,
    input wire logic dp_side_sel_i,
    input wire logic display_blank_n_i,
    input wire logic polarity_sel_i,
    output fdcdm_pkg::fdcdm_seg_t seg_o,
    output fdcdm_pkg::fdcdm_digit_t bcd_n_o,
    output logic [3:0] digit_strobe_o,
    output logic cascade_carry_o,
    output logic wrap_flag_n_o,
    output logic irq_o
);
    import fdcdm_pkg::*;

    // bcd increment across all decades at once
    function automatic fdcdm_count_t bcd_inc(input fdcdm_count_t v);
        fdcdm_count_t r;
        logic c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < `FDCDM_DIGITS; i++) begin
            if (c) begin
                if (v[i*`FDCDM_DIGIT_W +: `FDCDM_DIGIT_W] == `FDCDM_DIGIT_MAX)
                begin
                    r[i*`FDCDM_DIGIT_W +: `FDCDM_DIGIT_W] = `FDCDM_DIGIT_ZERO;
                end else begin
                    r[i*`FDCDM_DIGIT_W +: `FDCDM_DIGIT_W] =
                        v[i*`FDCDM_DIGIT_W +: `FDCDM_DIGIT_W]
                        + `FDCDM_DIGIT_ONE;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // segment bits g..a, active high before polarity
    function automatic fdcdm_seg_t seg_decode(input fdcdm_digit_t d);
        case (d)
            4'h0: seg_decode = 7'h3F;
            4'h1: seg_decode = 7'h06;
            4'h2: seg_decode = 7'h5B;
            4'h3: seg_decode = 7'h4F;
            4'h4: seg_decode = 7'h66;
            4'h5: seg_decode = 7'h6D;
            4'h6: seg_decode = 7'h7D;
            4'h7: seg_decode = 7'h07;
            4'h8: seg_decode = 7'h7F;
            4'h9: seg_decode = 7'h6F;
            default: seg_decode = `FDCDM_SEG_OFF;
        endcase
    endfunction

    // latch nibble for the digit the scanner points at
    function automatic fdcdm_digit_t digit_pick(input fdcdm_count_t v,
                                                input fdcdm_scan_t st);
        case (st)
            FDCDM_DIG_TOP: digit_pick = v[`FDCDM_NIB3 +: `FDCDM_DIGIT_W];
            FDCDM_DIG_2: digit_pick = v[`FDCDM_NIB2 +: `FDCDM_DIGIT_W];
            FDCDM_DIG_3: digit_pick = v[`FDCDM_NIB1 +: `FDCDM_DIGIT_W];
            default: digit_pick = v[`FDCDM_NIB0 +: `FDCDM_DIGIT_W];
        endcase
    endfunction

    // scanner step, bottom wraps to top
    function automatic fdcdm_scan_t scan_step(input fdcdm_scan_t st);
        case (st)
            FDCDM_DIG_TOP: scan_step = FDCDM_DIG_2;
            FDCDM_DIG_2: scan_step = FDCDM_DIG_3;
            FDCDM_DIG_3: scan_step = FDCDM_DIG_BOT;
            default: scan_step = FDCDM_DIG_TOP;
        endcase
    endfunction

    logic [`FDCDM_PIN_W-1:0] pins_raw;
    logic [`FDCDM_PIN_W-1:0] pins_s;
    logic cnt_s, scan_s, rstn_s, latch_s, zs_s, dp_s, blank_n_s, pol_s;
    logic cnt_prev_q, scan_prev_q;
    logic cnt_fall, scan_fall, ctr_clr;
    fdcdm_count_t count_q, count_d, latch_q;
    logic carry_q, carry_d, wrap_n_q, xfer_q, xfer_d;
    fdcdm_scan_t scan_q, scan_d;
    logic arm_q, arm_d, zs_prev_q;
    fdcdm_digit_t cur_digit;
    logic cur_zero, zs_eff, supp_blank;
    fdcdm_seg_t seg_raw, seg_d;
    fdcdm_digit_t bcd_raw, bcd_d;
    logic [3:0] strobe_d;
    logic [`FDCDM_IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_evt;
    logic [`FDCDM_IRQ_W-1:0] irq_clr;
    logic wb_req, wb_take, wr_stat, wr_mask;
    fdcdm_word_t rd_data, flags_word;

    // all pins pass the synchroniser before any logic sees them
    assign pins_raw[`FDCDM_PIN_COUNT] = count_i;
    assign pins_raw[`FDCDM_PIN_SCAN] = scan_i;
    assign pins_raw[`FDCDM_PIN_RESET] = reset_n_i;
    assign pins_raw[`FDCDM_PIN_LATCH] = latch_load_n_i;
    assign pins_raw[`FDCDM_PIN_ZS] = zero_suppress_stop_n_i;
    assign pins_raw[`FDCDM_PIN_DP] = dp_side_sel_i;
    assign pins_raw[`FDCDM_PIN_BLANK] = display_blank_n_i;
    assign pins_raw[`FDCDM_PIN_POL] = polarity_sel_i;

    fdcdm_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    // named views of the synchronised pins
    assign cnt_s = pins_s[`FDCDM_PIN_COUNT];
    assign scan_s = pins_s[`FDCDM_PIN_SCAN];
    assign rstn_s = pins_s[`FDCDM_PIN_RESET];
    assign latch_s = pins_s[`FDCDM_PIN_LATCH];
    assign zs_s = pins_s[`FDCDM_PIN_ZS];
    assign dp_s = pins_s[`FDCDM_PIN_DP];
    assign blank_n_s = pins_s[`FDCDM_PIN_BLANK];
    assign pol_s = pins_s[`FDCDM_PIN_POL];

    // falling edges of the external edge sources
    assign cnt_fall = cnt_prev_q & ~cnt_s;
    assign scan_fall = scan_prev_q & ~scan_s;
    assign ctr_clr = rst_i | ~rstn_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_prev_q <= 1'b1;
            scan_prev_q <= 1'b1;
        end else begin
            cnt_prev_q <= cnt_s;
            scan_prev_q <= scan_s;
        end
    end

    // counter, carry and transfer next values; reset wins over counting
    assign count_d = ctr_clr ? `FDCDM_COUNT_ZERO :
                     cnt_fall ? bcd_inc(count_q) : count_q;
    assign carry_d = (count_d == `FDCDM_COUNT_MAX);
    // transfer ends only at a count fall, so the old value gets latched
    assign xfer_d = ~latch_s ? 1'b1 :
                    cnt_fall ? 1'b0 : xfer_q;

    always_ff @(posedge clk_i) begin
        count_q <= count_d;
        carry_q <= carry_d;
        xfer_q <= rst_i ? 1'b1 : xfer_d;
    end

    // latches sample count_q before the same edge increments it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= `FDCDM_COUNT_ZERO;
        end else if (~latch_s | xfer_q) begin
            latch_q <= count_q;
        end
    end

    // wrap flag sticks low until the counter reset pin goes low
    always_ff @(posedge clk_i) begin
        if (ctr_clr) begin
            wrap_n_q <= 1'b1;
        end else if (cnt_fall && count_q == `FDCDM_COUNT_MAX) begin
            wrap_n_q <= 1'b0;
        end
    end

    // scanner: counter reset parks it on the top digit
    assign scan_d = ctr_clr ? FDCDM_DIG_TOP :
                    scan_fall ? scan_step(scan_q) : scan_q;

    always_ff @(posedge clk_i) begin
        scan_q <= scan_d;
    end

    // zero suppression; decided live so a changing latch is followed
    assign cur_digit = digit_pick(latch_q, scan_q);
    assign cur_zero = (cur_digit == `FDCDM_DIGIT_ZERO);
    // right-point mode keeps the previous stop level one digit longer
    assign zs_eff = zs_s | (~dp_s & zs_prev_q);
    assign supp_blank = arm_q & cur_zero & zs_eff
                        & (scan_q != FDCDM_DIG_BOT);
    assign arm_d = ctr_clr ? 1'b1 :
                   ~scan_fall ? arm_q :
                   (scan_q == FDCDM_DIG_BOT) ? 1'b1 :
                   (arm_q & cur_zero & zs_eff);

    always_ff @(posedge clk_i) begin
        arm_q <= arm_d;
        if (rst_i) begin
            zs_prev_q <= 1'b0;
        end else if (scan_fall) begin
            zs_prev_q <= zs_s;
        end
    end

    // output stage; scan low and blanking override the decoded digit
    assign strobe_d = scan_s ? scan_q : `FDCDM_STROBE_OFF;
    assign seg_raw = (~scan_s | ~blank_n_s | supp_blank) ?
                     `FDCDM_SEG_OFF : seg_decode(cur_digit);
    // bcd is never suppressed, only scan-off and blanking touch it
    assign bcd_raw = (~scan_s | ~blank_n_s) ? `FDCDM_BCD_OFF :
                     ~cur_digit;
    assign seg_d = pol_s ? seg_raw : ~seg_raw;
    assign bcd_d = pol_s ? bcd_raw : ~bcd_raw;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seg_o <= `FDCDM_SEG_OFF;
            bcd_n_o <= `FDCDM_BCD_OFF;
            digit_strobe_o <= `FDCDM_STROBE_OFF;
        end else begin
            seg_o <= seg_d;
            bcd_n_o <= bcd_d;
            digit_strobe_o <= strobe_d;
        end
    end

    assign cascade_carry_o = carry_q;
    assign wrap_flag_n_o = wrap_n_q;

    // wishbone: ack one cycle after the request, write at the ack edge
    assign wb_req = wb_cyc_i & wb_stb_i;
    assign wb_take = wb_req & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign wr_stat = wb_take & (wb_adr_i == `FDCDM_ADR_IRQ_STAT);
    assign wr_mask = wb_take & (wb_adr_i == `FDCDM_ADR_IRQ_MASK);

    // flag word shows the live pin-facing state
    assign flags_word = {24'h000000, strobe_d, 1'b0, xfer_q, carry_q,
                         wrap_n_q};
    // unmapped offsets read zero and still acknowledge
    assign rd_data =
        (wb_adr_i == `FDCDM_ADR_LIVE) ? {16'h0000, count_q} :
        (wb_adr_i == `FDCDM_ADR_LATCH) ? {16'h0000, latch_q} :
        (wb_adr_i == `FDCDM_ADR_FLAGS) ? flags_word :
        (wb_adr_i == `FDCDM_ADR_IRQ_STAT) ? {29'h00000000, irq_stat_q} :
        (wb_adr_i == `FDCDM_ADR_IRQ_MASK) ? {29'h00000000, irq_mask_q} :
        32'h00000000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            wb_dat_o <= rd_data;
        end
    end

    // sticky events; a set in the clearing cycle survives the clear
    assign irq_evt[`FDCDM_IRQ_WRAP] = ~ctr_clr & cnt_fall
                                      & (count_q == `FDCDM_COUNT_MAX);
    assign irq_evt[`FDCDM_IRQ_CARRY] = carry_d & ~carry_q;
    assign irq_evt[`FDCDM_IRQ_FREEZE] = xfer_q & ~xfer_d;
    assign irq_clr = wr_stat ? wb_dat_i[`FDCDM_IRQ_W-1:0] : `FDCDM_IRQ_RST;
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= `FDCDM_IRQ_RST;
            irq_mask_q <= `FDCDM_IRQ_RST;
            irq_o <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (wr_mask) begin
                irq_mask_q <= wb_dat_i[`FDCDM_IRQ_W-1:0];
            end
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // checks on the counter, latches and display path
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_clr_zero_count: assert property (
        ~rstn_s |=> count_q == `FDCDM_COUNT_ZERO
                    && scan_q == FDCDM_DIG_TOP && wrap_flag_n_o)
        else $error("counter reset did not clear state");

    a_count_inc_fall: assert property (
        cnt_fall && rstn_s |=> count_q == bcd_inc($past(count_q)))
        else $error("count did not increment on falling edge");

    a_count_hold: assert property (
        !cnt_fall && rstn_s |=> $stable(count_q))
        else $error("count moved without a falling edge");

    a_carry_at_max: assert property (
        cascade_carry_o == (count_q == `FDCDM_COUNT_MAX))
        else $error("cascade carry disagrees with count");

    a_wrap_on_roll: assert property (
        cnt_fall && rstn_s && count_q == `FDCDM_COUNT_MAX
        |=> !wrap_flag_n_o && count_q == `FDCDM_COUNT_ZERO)
        else $error("wrap flag not set on roll over");

    a_wrap_sticky: assert property (
        !wrap_flag_n_o && rstn_s |=> !wrap_flag_n_o)
        else $error("wrap flag released without reset");

    a_latch_follow: assert property (
        !latch_s |=> latch_q == $past(count_q))
        else $error("latch not following count");

    a_latch_frozen: assert property (
        !xfer_q && latch_s ##1 latch_s |-> $stable(latch_q)
        ##1 $stable(latch_q))
        else $error("latch changed while frozen");

    a_scan_low_off: assert property (
        !scan_s |=> digit_strobe_o == `FDCDM_STROBE_OFF
                    && bcd_n_o == ($past(pol_s) ? `FDCDM_BCD_OFF
                                                : ~`FDCDM_BCD_OFF))
        else $error("outputs not off while scan low");

    a_blank_segs_off: assert property (
        scan_s && !blank_n_s |=> seg_o == ($past(pol_s) ? `FDCDM_SEG_OFF
                                                        : ~`FDCDM_SEG_OFF))
        else $error("segments not off while blanked");

    a_bottom_shown: assert property (
        scan_s && blank_n_s && pol_s && scan_q == FDCDM_DIG_BOT
        |=> seg_o == seg_decode($past(cur_digit)))
        else $error("bottom digit was suppressed");

    a_no_supp_tied: assert property (
        !zs_s && !zs_prev_q |-> !supp_blank)
        else $error("suppression active with stop tied low");

    a_strobe_onehot: assert property (
        $onehot0(digit_strobe_o))
        else $error("more than one digit strobe high");

    c_wrap_seen: cover property (cnt_fall && count_q == `FDCDM_COUNT_MAX);
    c_freeze_seen: cover property (xfer_q && !xfer_d);
    c_supp_blank: cover property (scan_s && supp_blank);
    c_bottom_rearm: cover property (scan_fall && scan_q == FDCDM_DIG_BOT);

endmodule // fdcdm_top
`default_nettype wire

// file: verif/fdcdm_far_model.sv
/*
 * far-side model: count pulse source, transfer/reset controller and
 * scan source. assumes it shares clk_i with the block and that every
 * pin moves by non-blocking assignment just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module fdcdm_far_model (
    input wire logic clk_i,
    output logic count_o,
    output logic scan_o,
    output logic reset_n_o,
    output logic latch_load_n_o
);
    // idle levels: edges high, no reset, latches following
    initial begin
        count_o = 1'b1;
        scan_o = 1'b1;
        reset_n_o = 1'b1;
        latch_load_n_o = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // external edge source, 3 clocks low and 3 high: synchroniser limit
    task automatic pulse_count(input int n);
        repeat (n) begin
            @(posedge clk_i);
            count_o <= 1'b0;
            hold(3);
            count_o <= 1'b1;
            hold(2);
        end
    endtask

    // one scan level change; short steps keep scan far above reset rate
    task automatic set_scan(input logic v);
        @(posedge clk_i);
        scan_o <= v;
        hold(8);
    endtask

    // end transfer, let one count fall pass, then a narrow reset pulse;
    // 48 clocks is more than 1 us on either side of that fall
    task automatic xfer_reset();
        @(posedge clk_i);
        latch_load_n_o <= 1'b1;
        hold(48);
        pulse_count(1);
        hold(48);
        reset_n_o <= 1'b0;
        hold(48);
        reset_n_o <= 1'b1;
        hold(8);
    endtask

    task automatic set_latch(input logic v);
        @(posedge clk_i);
        latch_load_n_o <= v;
        hold(8);
    endtask
endmodule // fdcdm_far_model
`default_nettype wire

// file: verif/test_four_decade_counter_display_mux.sv
/*
 * self-checking bench: register bus, counting, transfer, wrap, scan.
 * assumes the design package is compiled first and the model file too.
 */
`timescale 1ns/1ps
`default_nettype none
module test_four_decade_counter_display_mux;
    import fdcdm_pkg::*;
    typedef struct {
        logic step, zs, dp, bl, pol;
        logic [3:0] stb;
        logic [6:0] seg;
        logic [3:0] bcd;
    } fdcdm_row_t;
    logic clk_i, rst_i, cyc, stb, we, zs, dp, bl, pol;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [3:0] wsel;
    fdcdm_word_t wdat, rdat, q;
    logic wb_ack_o, cnt, scn, rn, ld, carry, wrap_n, irq;
    fdcdm_seg_t seg;
    fdcdm_digit_t bcd;
    logic [3:0] strobe;
    int num_errors, compares;
    fdcdm_row_t rows[12];
    int cnt_n[2];
    logic [15:0] cnt_e[2];

    fdcdm_far_model far (.clk_i(clk_i), .count_o(cnt), .scan_o(scn),
        .reset_n_o(rn), .latch_load_n_o(ld));
    fdcdm_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(wb_ack_o),
        .count_i(cnt), .scan_i(scn), .reset_n_i(rn), .latch_load_n_i(ld),
        .zero_suppress_stop_n_i(zs), .dp_side_sel_i(dp),
        .display_blank_n_i(bl), .polarity_sel_i(pol), .seg_o(seg),
        .bcd_n_o(bcd), .digit_strobe_o(strobe), .cascade_carry_o(carry),
        .wrap_flag_n_o(wrap_n), .irq_o(irq));

    // 25 ns period
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // classic cycle: hold the request until ack is sampled high
    task automatic wb_io(input logic w, input logic [7:0] a,
                         input fdcdm_word_t d);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 50);
        if (t >= 50) num_errors++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb_io(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask

    task automatic summarize();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // a hang costs one error; 10000 count pulses dominate the run
    initial begin
        repeat (100000) @(posedge clk_i);
        num_errors++;
        summarize();
    end

    initial begin
        // latch 0012: digits top..bottom are 0,0,1,2
        rows = '{'{0,1,1,1,1,4'h1,7'h00,4'hF}, '{1,1,1,1,1,4'h2,7'h00,4'hF},
            '{1,1,1,1,1,4'h4,7'h06,4'hE}, '{1,1,1,1,1,4'h8,7'h5B,4'hD},
            '{1,0,1,1,1,4'h1,7'h3F,4'hF}, '{1,1,1,0,1,4'h2,7'h00,4'hF},
            '{1,1,1,1,0,4'h4,7'h79,4'h1}, '{1,1,1,1,1,4'h8,7'h5B,4'hD},
            '{1,1,1,1,1,4'h1,7'h00,4'hF}, '{1,1,0,1,1,4'h2,7'h00,4'hF},
            '{0,0,0,1,1,4'h2,7'h00,4'hF}, '{0,0,1,1,1,4'h2,7'h3F,4'hF}};
        cnt_n = '{1, 11};
        cnt_e = '{16'h0001, 16'h0012};
        {cyc, stb, we, sel, adr, wdat} = '0;
        wsel = 4'hF;
        {zs, dp, bl, pol} = 4'hF;
        num_errors = 0;
        compares = 0;
        rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        chk({seg, bcd, strobe, carry, wrap_n, irq}, {7'h00, 4'hF, 7'h02});
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h10, 0);
        rd(8'h0C, 0);
        rd(8'h40, 0);
        // lane 0 off, upper data bits and unmapped offsets are ignored
        wsel = 4'hE;
        wb_io(1'b1, 8'h10, 32'h0000_0007);
        wsel = 4'hF;
        rd(8'h10, 32'h0000_0000);
        wb_io(1'b1, 8'h10, 32'hFFFF_FFF8);
        rd(8'h10, 32'h0000_0000);
        wb_io(1'b1, 8'h40, 32'hFFFF_FFFF);
        rd(8'h0C, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        // counting rows, latches follow while the transfer is low
        for (int i = 0; i < 2; i++) begin
            far.pulse_count(cnt_n[i]);
            far.hold(8);
            rd(8'h00, {16'h0, cnt_e[i]});
            rd(8'h04, {16'h0, cnt_e[i]});
        end
        // scan rows: off levels while scan is low, then the next digit
        foreach (rows[i]) begin
            @(posedge clk_i);
            {zs, dp, bl, pol} <= {rows[i].zs, rows[i].dp, rows[i].bl,
                rows[i].pol};
            if (rows[i].step) begin
                far.set_scan(1'b0);
                chk({strobe, seg, bcd},
                    {4'h0, pol ? 11'h00F : 11'h7F0});
                far.set_scan(1'b1);
            end
            far.hold(8);
            chk({strobe, seg, bcd},
                {rows[i].stb, rows[i].seg, rows[i].bcd});
        end
        // transfer frozen by the first fall, kept through reset and counts
        far.xfer_reset();
        chk({strobe, wrap_n, carry}, {4'h1, 2'b10});
        far.pulse_count(1);
        far.hold(8);
        rd(8'h04, 32'h0012);
        rd(8'h00, 32'h0001);
        rd(8'h08, 32'h0000_0011);
        rd(8'h0C, 32'h4);
        wb_io(1'b1, 8'h0C, 32'h4);
        rd(8'h0C, 32'h0);
        far.set_latch(1'b0);
        // run up to 9999, then roll over with wrap and carry interrupts unmasked
        wb_io(1'b1, 8'h10, 32'h3);
        rd(8'h10, 32'h3);
        far.pulse_count(9998);
        far.hold(8);
        chk({carry, wrap_n, irq}, 3'b111);
        rd(8'h00, 32'h9999);
        wb_io(1'b1, 8'h0C, 32'h7);
        far.hold(3);
        chk(irq, 1'b0);
        far.pulse_count(1);
        far.hold(8);
        chk({carry, wrap_n, irq}, 3'b001);
        rd(8'h0C, 32'h1);
        wb_io(1'b1, 8'h10, 32'h0);
        far.hold(3);
        chk(irq, 1'b0);
        far.pulse_count(1);
        far.hold(8);
        chk(wrap_n, 1'b0);
        far.xfer_reset();
        chk({wrap_n, carry}, 2'b10);
        summarize();
    end
endmodule // test_four_decade_counter_display_mux
`default_nettype wire
